/* inc/reset_source_defines.svh */
/*
  Constants for the reset source sequencer: register map, field positions,
  reset values and timing figures.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef RESET_SOURCE_DEFINES_SVH
`define RESET_SOURCE_DEFINES_SVH

// clock and timing
`define CLK_HZ                 100000000
`define SUPPLY_TIMEOUT_MS      100
`define MISSING_CLOCK_MS       100
`define PIN_RELEASE_CYCLES     12
`define SUPPLY_TIMEOUT_CYCLES  ((`CLK_HZ / 1000) * `SUPPLY_TIMEOUT_MS)
`define MISSING_CLOCK_CYCLES   ((`CLK_HZ / 1000) * `MISSING_CLOCK_MS)

// register indices and byte addresses
`define RST_SOURCE_INDEX       12'h0EF
`define OSCCTL_INDEX           12'h000
`define RST_SOURCE_ADDR        12'h3BC
`define OSCCTL_ADDR            12'h000
`define ADDR_W                 12

// reset source register fields
`define PIN_FLAG_BIT           0
`define POR_FLAG_BIT           1
`define MCD_FLAG_BIT           2
`define WDT_FLAG_BIT           3
`define SW_FLAG_BIT            4
`define CMP_FLAG_BIT           5

// oscillator control register fields
`define MCD_ENABLE_BIT         7
`define OSCCTL_RESET           8'h00

// core state applied during and after reset
`define PC_RESET_VALUE         16'h0000
`define PORT_LATCH_RESET       8'hFF
`define WDT_INTERVAL_MAX       3'h7
`define CLK_SEL_INTERNAL       2'h0

// bus answers
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

/* inc/reset_source_pkg.sv */
/*
  Types shared by the reset source sequencer.
  Assumes reset_source_defines.svh supplies the numeric constants.
*/
package reset_source_pkg;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_POR,
    CAUSE_PIN,
    CAUSE_SW,
    CAUSE_CMP,
    CAUSE_MCD,
    CAUSE_WDT
  } reset_cause_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HOLD,
    ST_SUPPLY_WAIT,
    ST_STRETCH,
    ST_CLK_WAIT
  } seq_state_t;

  typedef struct packed {
    logic cmp;
    logic sw;
    logic wdt;
    logic mcd;
    logic por;
    logic pin;
  } reset_flags_t;

  typedef struct packed {
    logic por;
    logic pin;
    logic sw;
    logic cmp;
    logic mcd;
    logic wdt;
  } reset_sources_t;

endpackage

/* logic/reset_source_sequencer.sv */
/*
  Reset source sequencer: merges six reset sources into one internal reset,
  stretches it, drives the bidirectional reset pin for supply resets and
  records the cause in the reset source register over AXI4-Lite.
  Assumes all inputs are synchronous to sys_clk_in and that the core and
  peripherals treat core_reset_out as their synchronous reset.
*/
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
// Operation
// - reset halts core, ports, registers, interrupts
// - program counter restarts at zero
// - data memory kept, only stack pointer reloads
// - port latches all ones, pull-ups on
// - supply or software power-on drives pin low
// - internal clock, watchdog longest, wait stable
// - six sources, any one forces reset
// - power-up: hold, then pin low for timeout
// - monitor enable pin on large packages only
// - power-on sets its flag, others clear it
// - writing power-on bit forces power-on reset
// - supply drop resets, recovery like power-on
// - pin reset held twelve cycles after release
// - pin reset sets pin flag bit zero
// - missing clock timeout resets, pin untouched
// - missing clock flag bit two, else zero
// - missing clock detector needs enable bit
// - comparator reset enable is bit five
// - comparator low output forces reset
// - comparator flag reads one after its reset
// - software reset bit four, pin untouched
// - watchdog overflow resets, flag bit three
`include "reset_source_defines.svh"

module reset_source_sequencer
  import reset_source_pkg::*;
#(
  parameter bit LARGE_PACKAGE         = 1'b1,
  parameter int SUPPLY_TIMEOUT_CYCLES = `SUPPLY_TIMEOUT_CYCLES,
  parameter int MISSING_CLOCK_CYCLES  = `MISSING_CLOCK_CYCLES,
  parameter int PIN_RELEASE_CYCLES    = `PIN_RELEASE_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // axi4-lite write address and data
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // reset pin, active low, open drain
  input  wire logic        rst_pin_n_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe_out,
  // reset sources
  input  wire logic        supply_ok_in,
  input  wire logic        supply_monitor_enable_pin_in,
  input  wire logic        comparator_out_in,
  input  wire logic        watchdog_overflow_in,
  input  wire logic        core_clock_alive_in,
  input  wire logic        clock_stable_in,
  // reset state toward the core
  output logic             core_reset_out,
  output logic [15:0]      program_counter_out,
  output logic [7:0]       port_latch_out,
  output logic             weak_pullup_enable_out,
  output logic [1:0]       clock_select_out,
  output logic             watchdog_enable_out,
  output logic [2:0]       watchdog_interval_out
);

  localparam logic [31:0] SUPPLY_LAST = 32'(SUPPLY_TIMEOUT_CYCLES - 1);
  localparam logic [31:0] MCD_LAST    = 32'(MISSING_CLOCK_CYCLES - 1);
  localparam logic [31:0] PIN_LAST    = 32'(PIN_RELEASE_CYCLES - 1);

  seq_state_t     state_reg;
  reset_cause_t   cause_reg;
  reset_flags_t   flags_reg;
  reset_sources_t src;
  logic [31:0]    count_reg;
  logic [31:0]    mcd_count_reg;
  logic           mcd_timeout_reg;
  logic [7:0]     oscctl_reg;
  logic           cmp_enable_reg;
  logic           sw_por_req_reg;
  logic           sw_rst_req_reg;
  logic           monitor_on;
  logic           any_src;
  logic           level_src;
  logic           in_reset_next;

  // axi holding registers
  logic [11:0]    awaddr_reg;
  logic [31:0]    wdata_reg;
  logic [3:0]     wstrb_reg;
  logic           aw_held_reg;
  logic           w_held_reg;
  logic           wr_fire;
  logic           wr_rst_source;
  logic           wr_oscctl;

  function automatic reset_cause_t pick_cause(input reset_sources_t s);
    if (s.por) begin
      pick_cause = CAUSE_POR;
    end else if (s.pin) begin
      pick_cause = CAUSE_PIN;
    end else if (s.mcd) begin
      pick_cause = CAUSE_MCD;
    end else if (s.wdt) begin
      pick_cause = CAUSE_WDT;
    end else if (s.cmp) begin
      pick_cause = CAUSE_CMP;
    end else if (s.sw) begin
      pick_cause = CAUSE_SW;
    end else begin
      pick_cause = CAUSE_NONE;
    end
  endfunction

  assign monitor_on = LARGE_PACKAGE ? supply_monitor_enable_pin_in : 1'b1;

  always_comb begin
    src.por = (monitor_on && !supply_ok_in) || sw_por_req_reg;
    // our own drive reads back low, so the pin counts only when released
    src.pin = !rst_pin_n_in && !rst_pin_oe_out;
    src.sw  = sw_rst_req_reg;
    src.cmp = cmp_enable_reg && !comparator_out_in;
    src.mcd = mcd_timeout_reg;
    src.wdt = watchdog_overflow_in;
  end

  assign any_src   = |src;
  assign level_src = (monitor_on && !supply_ok_in) || src.pin || src.cmp;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_SUPPLY_WAIT;
      cause_reg <= CAUSE_POR;
      count_reg <= 32'h00000000;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (any_src) begin
            state_reg <= ST_HOLD;
            cause_reg <= pick_cause(src);
          end
        end
        ST_HOLD: begin
          // a supply fault during another reset turns it into power-on
          if (src.por) begin
            cause_reg <= CAUSE_POR;
          end
          count_reg <= 32'h00000000;
          if (!level_src) begin
            if (src.por || cause_reg == CAUSE_POR) begin
              state_reg <= ST_SUPPLY_WAIT;
            end else begin
              state_reg <= ST_STRETCH;
            end
          end
        end
        ST_SUPPLY_WAIT: begin
          if (level_src) begin
            state_reg <= ST_HOLD;
            if (src.por) begin
              cause_reg <= CAUSE_POR;
            end
          end else if (count_reg == SUPPLY_LAST) begin
            state_reg <= ST_CLK_WAIT;
          end else begin
            count_reg <= count_reg + 32'h00000001;
          end
        end
        ST_STRETCH: begin
          if (level_src) begin
            state_reg <= ST_HOLD;
            if (src.por) begin
              cause_reg <= CAUSE_POR;
            end
          end else if (count_reg == PIN_LAST) begin
            state_reg <= ST_CLK_WAIT;
          end else begin
            count_reg <= count_reg + 32'h00000001;
          end
        end
        ST_CLK_WAIT: begin
          if (level_src) begin
            state_reg <= ST_HOLD;
          end else if (clock_stable_in) begin
            state_reg <= ST_RUN;
          end
        end
        default: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  assign in_reset_next = (state_reg != ST_RUN) || any_src ||
                         (state_reg == ST_CLK_WAIT && !clock_stable_in);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      core_reset_out <= 1'b1;
    end else begin
      core_reset_out <= in_reset_next;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rst_pin_oe_out <= 1'b1;
      rst_pin_out    <= 1'b0;
    end else begin
      rst_pin_out    <= 1'b0;
      rst_pin_oe_out <= src.por ||
                        (cause_reg == CAUSE_POR && state_reg != ST_RUN &&
                         state_reg != ST_CLK_WAIT);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      program_counter_out    <= `PC_RESET_VALUE;
      port_latch_out         <= `PORT_LATCH_RESET;
      weak_pullup_enable_out <= 1'b1;
      clock_select_out       <= `CLK_SEL_INTERNAL;
      watchdog_enable_out    <= 1'b0;
      watchdog_interval_out  <= `WDT_INTERVAL_MAX;
    end else if (in_reset_next) begin
      program_counter_out    <= `PC_RESET_VALUE;
      port_latch_out         <= `PORT_LATCH_RESET;
      weak_pullup_enable_out <= 1'b1;
      clock_select_out       <= `CLK_SEL_INTERNAL;
      watchdog_enable_out    <= 1'b0;
      watchdog_interval_out  <= `WDT_INTERVAL_MAX;
    end else begin
      // watchdog runs from the first cycle out of reset
      watchdog_enable_out    <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      flags_reg <= '0;
    end else if (state_reg == ST_CLK_WAIT && clock_stable_in) begin
      // latch on every exit, a pending source re-enters and latches again
      flags_reg     <= '0;
      flags_reg.por <= (cause_reg == CAUSE_POR);
      flags_reg.pin <= (cause_reg == CAUSE_PIN);
      flags_reg.mcd <= (cause_reg == CAUSE_MCD);
      flags_reg.wdt <= (cause_reg == CAUSE_WDT);
      flags_reg.cmp <= (cause_reg == CAUSE_CMP);
      flags_reg.sw  <= (cause_reg == CAUSE_SW);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || core_reset_out || !oscctl_reg[`MCD_ENABLE_BIT] ||
        core_clock_alive_in) begin
      mcd_count_reg   <= 32'h00000000;
      mcd_timeout_reg <= 1'b0;
    end else if (mcd_count_reg == MCD_LAST) begin
      mcd_timeout_reg <= 1'b1;
    end else begin
      mcd_count_reg   <= mcd_count_reg + 32'h00000001;
    end
  end

  // write channel capture, address and data in either order
  assign wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  assign wr_rst_source = wr_fire && awaddr_reg == `RST_SOURCE_ADDR && wstrb_reg[0];
  assign wr_oscctl = wr_fire && awaddr_reg == `OSCCTL_ADDR && wstrb_reg[0];

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      awaddr_reg        <= 12'h000;
      wdata_reg         <= 32'h00000000;
      wstrb_reg         <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        awaddr_reg        <= s_axi_awaddr_in;
        aw_held_reg       <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wdata_reg        <= s_axi_wdata_in;
        wstrb_reg        <= s_axi_wstrb_in;
        w_held_reg       <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg      <= 1'b0;
        w_held_reg       <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        if (awaddr_reg == `RST_SOURCE_ADDR || awaddr_reg == `OSCCTL_ADDR) begin
          s_axi_bresp_out <= `RESP_OKAY;
        end else begin
          s_axi_bresp_out <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // register writes, write meanings differ from read
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      oscctl_reg     <= `OSCCTL_RESET;
      cmp_enable_reg <= 1'b0;
      sw_por_req_reg <= 1'b0;
      sw_rst_req_reg <= 1'b0;
    end else begin
      sw_por_req_reg <= wr_rst_source && wdata_reg[`POR_FLAG_BIT];
      sw_rst_req_reg <= wr_rst_source && wdata_reg[`SW_FLAG_BIT];
      if (core_reset_out) begin
        // control bits take reset values while the core is held
        oscctl_reg     <= `OSCCTL_RESET;
        cmp_enable_reg <= 1'b0;
      end else begin
        if (wr_rst_source) begin
          cmp_enable_reg <= wdata_reg[`CMP_FLAG_BIT];
        end
        if (wr_oscctl) begin
          oscctl_reg <= wdata_reg[7:0];
        end
      end
    end
  end

  // read channel
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rresp_out   <= `RESP_OKAY;
        if (s_axi_araddr_in == `RST_SOURCE_ADDR) begin
          s_axi_rdata_out <= {26'h0000000, flags_reg};
        end else if (s_axi_araddr_in == `OSCCTL_ADDR) begin
          s_axi_rdata_out <= {24'h000000, oscctl_reg};
        end else begin
          s_axi_rdata_out <= 32'h00000000;
          s_axi_rresp_out <= `RESP_SLVERR;
        end
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

endmodule

/* tb/reset_seq_props.sv */
/*
  Port checker for reset_source_sequencer, bound into every instance.
  Assumes one clock domain and a synchronous active-high rst_in.
*/
module reset_seq_props #(
  parameter int SUPPLY_TIMEOUT_CYCLES = 50
) (
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  // pin and sources
  input wire logic        rst_pin_n_in,
  input wire logic        rst_pin_oe_out,
  input wire logic        rst_pin_out,
  input wire logic        supply_ok_in,
  input wire logic        supply_monitor_enable_pin_in,
  input wire logic        watchdog_overflow_in,
  input wire logic        clock_stable_in,
  // core side
  input wire logic        core_reset_out,
  input wire logic [15:0] program_counter_out,
  input wire logic [7:0]  port_latch_out,
  input wire logic        weak_pullup_enable_out,
  input wire logic [1:0]  clock_select_out,
  input wire logic        watchdog_enable_out,
  input wire logic [2:0]  watchdog_interval_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int oe_cnt_reg;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  // cycles the pin has been driven so far
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !rst_pin_oe_out) begin
      oe_cnt_reg <= 0;
    end else begin
      oe_cnt_reg <= oe_cnt_reg + 1;
    end
  end

  sequence s_pin_release;
    $rose(rst_pin_n_in) && !$past(rst_pin_oe_out);
  endsequence
  sequence s_hold_twelve;
    core_reset_out[*8] ##1 core_reset_out[*4];
  endsequence

  property p_halt;
    core_reset_out |-> program_counter_out == 16'h0000 && !watchdog_enable_out;
  endproperty
  property p_latch;
    weak_pullup_enable_out && (!core_reset_out || port_latch_out == 8'hFF);
  endproperty
  property p_exit;
    $fell(core_reset_out) |-> $past(clock_stable_in, 2) && clock_select_out == 2'h0
      && watchdog_enable_out && watchdog_interval_out == 3'h7;
  endproperty
  property p_any_src;
    !rst_pin_n_in || watchdog_overflow_in || (supply_monitor_enable_pin_in && !supply_ok_in)
      |=> core_reset_out;
  endproperty
  property p_pin_hold;
    s_pin_release |=> s_hold_twelve;
  endproperty
  property p_pin_low;
    rst_pin_oe_out |-> !rst_pin_out;
  endproperty
  property p_supply_pin;
    supply_monitor_enable_pin_in && !supply_ok_in |-> ##[1:2] rst_pin_oe_out;
  endproperty
  property p_wdt_quiet;
    watchdog_overflow_in && supply_ok_in && !rst_pin_oe_out |=> !rst_pin_oe_out;
  endproperty
  property p_oe_time;
    $fell(rst_pin_oe_out) |-> oe_cnt_reg >= SUPPLY_TIMEOUT_CYCLES;
  endproperty

  a_halt: assert property (p_halt)
    else $error("core state not held while in reset");
  a_latch: assert property (p_latch)
    else $error("port latches or pull-ups wrong");
  a_exit: assert property (p_exit)
    else $error("reset exit state wrong");
  a_any_src: assert property (p_any_src)
    else $error("reset source did not enter reset");
  a_pin_hold: assert property (p_pin_hold)
    else $error("reset ended early after pin release");
  a_supply_pin: assert property (p_supply_pin)
    else $error("supply fault did not drive pin");
  a_wdt_quiet: assert property (p_wdt_quiet)
    else $error("watchdog reset drove the pin");
  a_oe_time: assert property (p_oe_time)
    else $error("pin released before supply timeout");
  a_pin_low: assert property (p_pin_low)
    else $error("reset pin driven to a high level");
endmodule

bind reset_source_sequencer reset_seq_props #(
  .SUPPLY_TIMEOUT_CYCLES(SUPPLY_TIMEOUT_CYCLES)
) i_props (
  .sys_clk_in, .rst_in, .rst_pin_n_in, .rst_pin_oe_out, .rst_pin_out, .supply_ok_in,
  .supply_monitor_enable_pin_in, .watchdog_overflow_in, .clock_stable_in, .core_reset_out,
  .program_counter_out, .port_latch_out, .weak_pullup_enable_out, .clock_select_out,
  .watchdog_enable_out, .watchdog_interval_out
);

/* tb/reset_partner.sv */
/*
  Far side: external reset circuit on the open-drain pin, and supply monitor.
  Assumes the bench commands pin pulls and supply dips on clock edges.
*/
module reset_partner (
  // commands from the bench
  input  wire logic sys_clk_in,
  input  wire logic pull_low_in,
  input  wire logic dip_in,
  // sequencer pin driver
  input  wire logic dut_oe_in,
  // toward the sequencer
  output logic      pin_n_out,
  output logic      supply_ok_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pull_reg;

  always_ff @(posedge sys_clk_in) pull_reg <= pull_low_in;
  // wired pin with pull-up: either party low wins
  assign pin_n_out = !(pull_reg || dut_oe_in);
  // monitor reports a dip one edge late
  always_ff @(posedge sys_clk_in) supply_ok_out <= !dip_in;
endmodule

/* tb/tb_top.sv */
/*
  Self-checking bench for reset_source_sequencer with random source order.
  Assumes short sim counts: supply timeout 50, missing clock 40 cycles.
*/
`include "reset_source_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_in, rst_in, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pin_n, pin_oe, supply_ok;
  logic        supply_monitor_enable_pin, cmp, wdt, alive, stable, pull, dip, core_rst, seen_oe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          n_mismatch, n_tests, cyc, k;

  reset_source_sequencer #(.SUPPLY_TIMEOUT_CYCLES(50), .MISSING_CLOCK_CYCLES(40)) i_dut (
    .sys_clk_in, .rst_in, .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .rst_pin_n_in(pin_n), .rst_pin_out(), .rst_pin_oe_out(pin_oe),
    .supply_ok_in(supply_ok), .supply_monitor_enable_pin_in(supply_monitor_enable_pin),
    .comparator_out_in(cmp), .watchdog_overflow_in(wdt), .core_clock_alive_in(alive),
    .clock_stable_in(stable), .core_reset_out(core_rst), .program_counter_out(),
    .port_latch_out(), .weak_pullup_enable_out(), .clock_select_out(),
    .watchdog_enable_out(), .watchdog_interval_out()
  );

  reset_partner i_partner (
    .sys_clk_in, .pull_low_in(pull), .dip_in(dip), .dut_oe_in(pin_oe),
    .pin_n_out(pin_n), .supply_ok_out(supply_ok)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = !sys_clk_in;
  end

  // clock source settles at random moments, so exits wait on it
  always @(posedge sys_clk_in) begin
    stable <= ($urandom % 4) != 0;
    if (pin_oe) seen_oe <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] flag_of(input int b);
    return 32'h1 << b;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge sys_clk_in); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk_in); while (!arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge sys_clk_in); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // wait through a reset, then read the cause
  task automatic src_check(input int b, input logic oe);
    while (!core_rst) @(posedge sys_clk_in);
    while (core_rst) @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    rd_reg(`RST_SOURCE_ADDR);
    check(rd, flag_of(b));
    check(seen_oe, oe);
    seen_oe <= 1'b0;
  endtask

  task automatic fire(input int s);
    case (s)
      0: pull <= 1'b1;
      1: wdt <= 1'b1;
      2: wr(`RST_SOURCE_ADDR, 32'h10);
      3: wr(`RST_SOURCE_ADDR, 32'h02);
      default: dip <= 1'b1;
    endcase
    repeat (2 + $urandom % 12) @(posedge sys_clk_in);
    {pull, wdt, dip} <= '0;
    src_check(s == 0 ? 0 : s == 1 ? 3 : s == 2 ? 4 : 1, s > 2);
  endtask

  initial begin
    void'($urandom(32'h5B0A7D7D));
    {awvalid, wvalid, bready, arvalid, rready, wdt, pull, dip, seen_oe} = '0;
    {rst_in, supply_monitor_enable_pin, cmp, alive, stable} = '1;
    {awaddr, araddr, wdata, cyc} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    src_check(1, 1'b1);
    // pin, watchdog, software, power-on write and supply dip once, then a random run of them
    for (k = 0; k < 13; k++) fire(k < 5 ? k : $urandom % 5);
    supply_monitor_enable_pin <= 1'b0;
    dip <= 1'b1;
    repeat (20) @(posedge sys_clk_in);
    dip <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    check(core_rst, 1'b0);
    supply_monitor_enable_pin <= 1'b1;
    // comparator output already steady before reset enable
    cmp <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    check(core_rst, 1'b0);
    cmp <= 1'b1;
    @(posedge sys_clk_in);
    wr(`RST_SOURCE_ADDR, 32'h20);
    cmp <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    cmp <= 1'b1;
    src_check(5, 1'b0);
    alive <= 1'b0;
    repeat (45) @(posedge sys_clk_in);
    check(core_rst, 1'b0);
    alive <= 1'b1;
    @(posedge sys_clk_in);
    wr(`OSCCTL_ADDR, 32'h80);
    alive <= 1'b0;
    repeat (45) @(posedge sys_clk_in);
    alive <= 1'b1;
    src_check(2, 1'b0);
    rd_reg(12'h100);
    check(rs, `RESP_SLVERR);
    check(rd, 32'h0);
    summarize();
  end
endmodule
